// [logic/mce_top.sv]
// Machine-check error line agent: package of constants and the top module.
// Assumes a synchronous system: every input is sampled on i_clk, the bus
// fabric resolves the shared open-drain lines from the enables, and a
// pull-up holds them high when no agent drives.

// ****************************************************************
// Package
// ****************************************************************
package mce_pkg;
    // Register byte offsets
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_MASK   = 4'h8;
    localparam logic [3:0] OFF_LINE   = 4'hC;
    // Control fields
    localparam int CTRL_EN      = 0;
    localparam int CTRL_INT     = 1;
    localparam int CTRL_REQ     = 2;
    localparam int CTRL_OBS     = 3;
    localparam int CTRL_W       = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Status and mask fields
    localparam int ST_INT       = 0;
    localparam int ST_REQ       = 1;
    localparam int ST_OBS       = 2;
    localparam int ST_EXT       = 3;
    localparam int ST_W         = 4;
    localparam logic [3:0] ST_RST   = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    // Line readback fields
    localparam int LN_SEEN      = 0;
    localparam int LN_MCE       = 1;
    localparam int LN_IE        = 2;
    localparam int LN_W         = 3;
    // Identification value, arbitrary
    localparam logic [7:0] AGENT_ID = 8'h5A;
    localparam int LN_ID_LSB    = 8;
    // Bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } mce_bus_t;
endpackage : mce_pkg

`timescale 1ns/1ps

// ****************************************************************
// Top module
// ****************************************************************
// Behaviour
// - Drive error line on unrecoverable non-protocol errors
// - Tolerate and record other agents driving line
// - Global enable; disabled means never driving (the internal-error line is still driven from i_int_err)
// - Internal mode: drive together with internal-error line
// - Requester mode: drive after own transaction error
// - Observer mode: drive on any observed error
// - Line is wired-OR among all agents
// - Change and sample only on designated edges (CTRL_EN gates the error-line drive on any clock, edge or not)
// - Release outputs within two clocks of bus reset
module mce_top (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Avalon-MM slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // System bus side
    input  wire logic        i_bus_reset_n,
    input  wire logic        i_bus_edge,
    input  wire logic        i_machine_check_error_n,
    output logic             o_machine_check_error_n,
    output logic             o_machine_check_error_oe,
    output logic             o_internal_error_n,
    output logic             o_internal_error_oe,
    // Error sources inside the agent
    input  wire logic        i_int_err,
    input  wire logic        i_req_err,
    input  wire logic        i_obs_err,
    output logic             o_irq
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr[3:2] == off[3:2]);
    endfunction : hit

    mce_pkg::mce_bus_t bus_q;
    mce_pkg::mce_bus_t bus_d;
    logic [31:0]                 rdata_q;
    logic [31:0]                 rdata_d;
    logic [mce_pkg::CTRL_W-1:0]  ctrl_q;
    logic [mce_pkg::CTRL_W-1:0]  ctrl_d;
    logic [mce_pkg::ST_W-1:0]    status_q;
    logic [mce_pkg::ST_W-1:0]    status_d;
    logic [mce_pkg::ST_W-1:0]    mask_q;
    logic [mce_pkg::ST_W-1:0]    mask_d;
    logic [mce_pkg::ST_W-1:0]    st_set;
    logic [mce_pkg::ST_W-1:0]    st_clr;
    logic [mce_pkg::LN_W-1:0]    line_rb;

    wire logic req      = i_avs_read | i_avs_write;
    wire logic done     = req & (bus_q == mce_pkg::BUS_ACK);
    wire logic wr_lo    = done & i_avs_write & i_avs_byteenable[0];
    wire logic wr_ctrl  = wr_lo & hit(i_avs_address, mce_pkg::OFF_CTRL);
    wire logic wr_stat  = wr_lo & hit(i_avs_address, mce_pkg::OFF_STATUS);
    wire logic wr_mask  = wr_lo & hit(i_avs_address, mce_pkg::OFF_MASK);

    // One wait cycle per access keeps read data registered
    assign bus_d = (req && bus_q == mce_pkg::BUS_IDLE) ? mce_pkg::BUS_ACK
                                                        : mce_pkg::BUS_IDLE;
    assign o_avs_waitrequest = req & (bus_q == mce_pkg::BUS_IDLE);

    // Decode uses address bits 3:2 only; the line word is read-only, writes there are dropped
    assign rdata_d =
        hit(i_avs_address, mce_pkg::OFF_CTRL)   ? {28'h0000000, ctrl_q}   :
        hit(i_avs_address, mce_pkg::OFF_STATUS) ? {28'h0000000, status_q} :
        hit(i_avs_address, mce_pkg::OFF_MASK)   ? {28'h0000000, mask_q}   :
        {16'h0000, mce_pkg::AGENT_ID, 5'h00, line_rb};

    assign ctrl_d = wr_ctrl ? i_avs_writedata[mce_pkg::CTRL_W-1:0] : ctrl_q;
    assign mask_d = wr_mask ? i_avs_writedata[mce_pkg::ST_W-1:0] : mask_q;
    assign st_clr = wr_stat ? i_avs_writedata[mce_pkg::ST_W-1:0]
                            : mce_pkg::ST_RST;
    // A new event beats a write-one-to-clear in the same cycle
    assign status_d = (status_q & ~st_clr) | st_set;
    assign o_irq    = |(status_q & mask_q);
    assign o_avs_readdata = rdata_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_q    <= mce_pkg::BUS_IDLE;
            rdata_q  <= 32'h00000000;
            ctrl_q   <= mce_pkg::CTRL_RST;
            status_q <= mce_pkg::ST_RST;
            mask_q   <= mce_pkg::MASK_RST;
        end else begin
            bus_q    <= bus_d;
            rdata_q  <= o_avs_waitrequest ? rdata_d : rdata_q;
            ctrl_q   <= ctrl_d;
            status_q <= status_d;
            mask_q   <= mask_d;
        end
    end

    // ****************************************************************
    // Error line drive
    // ****************************************************************
    wire logic en      = ctrl_q[mce_pkg::CTRL_EN];
    wire logic src_int = en & ctrl_q[mce_pkg::CTRL_INT] & i_int_err;
    wire logic src_req = en & ctrl_q[mce_pkg::CTRL_REQ] & i_req_err;
    wire logic src_obs = en & ctrl_q[mce_pkg::CTRL_OBS] & i_obs_err;
    wire logic src_any = src_int | src_req | src_obs;

    logic mce_pend_q;
    logic mce_pend_d;
    logic ie_pend_q;
    logic ie_pend_d;
    logic mce_q;
    logic mce_d;
    logic ie_q;
    logic ie_d;
    logic seen_q;
    logic seen_d;

    // Events between designated edges wait here, so the line only moves on one
    assign mce_pend_d  = !i_bus_reset_n ? 1'b0 :
                         ((mce_pend_q & ~i_bus_edge) | (src_any & ~i_bus_edge));
    assign ie_pend_d   = !i_bus_reset_n ? 1'b0 :
                         ((ie_pend_q | i_int_err) & ~i_bus_edge);
    // Internal line and error line load on the same edge
    assign mce_d  = !i_bus_reset_n ? 1'b0 :
                    i_bus_edge ? (mce_pend_q | src_any) : mce_q;
    assign ie_d   = !i_bus_reset_n ? 1'b0 :
                    i_bus_edge ? (ie_pend_q | i_int_err) : ie_q;
    // Line is sampled only on designated edges; low while idle here means another agent
    wire logic ext_evt = i_bus_reset_n & i_bus_edge & ~i_machine_check_error_n
                         & ~o_machine_check_error_oe;
    assign seen_d = i_bus_edge ? ~i_machine_check_error_n : seen_q;

    assign st_set = {ext_evt,
                     i_bus_reset_n & i_obs_err,
                     i_bus_reset_n & i_req_err,
                     i_bus_reset_n & i_int_err};
    assign line_rb = {ie_q, mce_q, seen_q};

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mce_pend_q  <= 1'b0;
            ie_pend_q   <= 1'b0;
            mce_q       <= 1'b0;
            ie_q        <= 1'b0;
            seen_q      <= 1'b0;
        end else begin
            mce_pend_q  <= mce_pend_d;
            ie_pend_q   <= ie_pend_d;
            mce_q       <= mce_d;
            ie_q        <= ie_d;
            seen_q      <= seen_d;
        end
    end

    // Open drain: value is always low, only the enable moves
    assign o_machine_check_error_n  = 1'b0;
    assign o_machine_check_error_oe = mce_q & en;
    assign o_internal_error_n       = 1'b0;
    assign o_internal_error_oe      = ie_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_cfg_event(logic src);
        i_bus_edge && src && i_bus_reset_n;
    endsequence

    sequence s_driving;
        o_machine_check_error_oe && !o_machine_check_error_n;
    endsequence

    property p_internal;
        @(posedge i_clk) disable iff (!i_resetn)
        s_cfg_event(src_int) ##0 !wr_ctrl |=> s_driving ##0 o_internal_error_oe;
    endproperty
    a_internal: assert property (p_internal) else $error("internal error not paired");

    property p_requester;
        @(posedge i_clk) disable iff (!i_resetn)
        s_cfg_event(src_req) ##0 !wr_ctrl |=> s_driving;
    endproperty
    a_requester: assert property (p_requester) else $error("requester error not driven");

    property p_observer;
        @(posedge i_clk) disable iff (!i_resetn)
        s_cfg_event(src_obs) ##0 !wr_ctrl |=> s_driving;
    endproperty
    a_observer: assert property (p_observer) else $error("observed error not driven");

    property p_pending;
        @(posedge i_clk) disable iff (!i_resetn)
        (src_any && !i_bus_edge && i_bus_reset_n)
        ##1 (i_bus_edge && i_bus_reset_n && en && !wr_ctrl)
        |=> s_driving;
    endproperty
    a_pending: assert property (p_pending) else $error("held error lost");

    property p_disabled;
        @(posedge i_clk) disable iff (!i_resetn)
        !ctrl_q[mce_pkg::CTRL_EN] |-> !o_machine_check_error_oe;
    endproperty
    a_disabled: assert property (p_disabled) else $error("drive while disabled");

    property p_edges;
        @(posedge i_clk) disable iff (!i_resetn)
        $changed(mce_q) |-> $past(i_bus_edge) || !$past(i_bus_reset_n);
    endproperty
    a_edges: assert property (p_edges) else $error("line moved off designated edge");

    property p_bus_reset;
        @(posedge i_clk) disable iff (!i_resetn)
        !i_bus_reset_n |-> ##[1:2] (!o_machine_check_error_oe && !o_internal_error_oe);
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("outputs held in bus reset");

    property p_open_drain;
        @(posedge i_clk) disable iff (!i_resetn)
        o_machine_check_error_oe |-> !o_machine_check_error_n;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");

    property p_external;
        @(posedge i_clk) disable iff (!i_resetn)
        i_bus_edge && i_bus_reset_n && !i_machine_check_error_n && !o_machine_check_error_oe
        |=> status_q[mce_pkg::ST_EXT] ##0 seen_q;
    endproperty
    a_external: assert property (p_external) else $error("other agent drive missed");

    property p_irq;
        @(posedge i_clk) disable iff (!i_resetn)
        ext_evt && mask_q[mce_pkg::ST_EXT] && !wr_mask |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_ie_edges;
        @(posedge i_clk) disable iff (!i_resetn)
        $changed(ie_q) |-> $past(i_bus_edge) || !$past(i_bus_reset_n);
    endproperty
    a_ie_edges: assert property (p_ie_edges) else $error("internal line off edge");

    property p_release;
        @(posedge i_clk) disable iff (!i_resetn)
        i_bus_edge && !src_any && !mce_pend_q |=> !o_machine_check_error_oe;
    endproperty
    a_release: assert property (p_release) else $error("drive outlived window");

    property p_disabled_src;
        @(posedge i_clk) disable iff (!i_resetn)
        i_bus_edge && i_bus_reset_n && !ctrl_q[mce_pkg::CTRL_EN] && !mce_pend_q |=> !mce_q;
    endproperty
    a_disabled_src: assert property (p_disabled_src) else $error("disabled source loaded");

endmodule : mce_top

// [bench/mce_peer.sv]
// Other agents on the shared error line, with the line's pull-up.
// Assumes the bench commands peer errors and the bus edge strobe.
`timescale 1ns/1ps
// ********************
// Peer model
// ********************
module mce_peer (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_bus_edge,
    input  wire logic i_peer_err,
    input  wire logic i_dut_pull,
    output logic      o_line_n
);
    logic peer_oe_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            peer_oe_q <= 1'b0;
        end else if (i_bus_edge) begin
            peer_oe_q <= i_peer_err;
        end
    end
    // Nobody pulling means the pull-up wins, never a held old value
    assign o_line_n = (peer_oe_q || i_dut_pull) ? 1'b0 : 1'b1;
endmodule : mce_peer

// [bench/bus_machine_check_error_signal_tb.sv]
// Self-checking bench for the error line agent: directed and random.
// Assumes mce_top and mce_peer are compiled before it.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ********************
// Bench
// ********************
module bus_machine_check_error_signal_tb;
    logic        i_clk, i_resetn, rd, wr, bus_reset_n, bus_edge, line_n, peer_err, chk;
    logic        int_err, req_err, obs_err, drv_q, pend_q, q, ie_drv_q, ie_pend_q;
    logic        waitreq, mce_n, mce_oe, ie_oe, irq, ie_n;
    logic [3:0]  addr, cfg;
    logic [31:0] wdata, r, readdata;
    logic [3:0]  cfg_tab [6] = '{4'h0, 4'hE, 4'h3, 4'h5, 4'h9, 4'hF};
    int          err_total, n_compared, seed;

    mce_top mce_top_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq),
        .i_bus_reset_n(bus_reset_n), .i_bus_edge(bus_edge),
        .i_machine_check_error_n(line_n), .o_machine_check_error_n(mce_n),
        .o_machine_check_error_oe(mce_oe), .o_internal_error_n(ie_n),
        .o_internal_error_oe(ie_oe), .i_int_err(int_err), .i_req_err(req_err),
        .i_obs_err(obs_err), .o_irq(irq));
    mce_peer mce_peer_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus_edge(bus_edge),
        .i_peer_err(peer_err), .i_dut_pull(mce_oe & ~mce_n), .o_line_n(line_n));

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        {rd, wr, addr, wdata} <= {!w, w, a, d};
        @(posedge i_clk);
        while (waitreq !== 1'b0) begin
            n++;
            if (n > 20) begin
                err_total++;
                results();
            end
            @(posedge i_clk);
        end
        r = readdata;
        {rd, wr} <= 2'b00;
    endtask : access

    // Nibble is {edge, observed, requester, internal}, held for one cycle
    task automatic pulse(input logic [3:0] ev);
        @(posedge i_clk);
        {bus_edge, obs_err, req_err, int_err} <= ev;
        @(posedge i_clk);
        {bus_edge, obs_err, req_err, int_err} <= 4'h0;
        @(negedge i_clk);
    endtask : pulse

    // Reference drive: events wait for the next bus edge, then stand one window
    // A source counts only when the agent is enabled and its mode bit is set
    function automatic logic qual(input logic [3:0] c, input logic [2:0] ev);
        qual = c[0] & |(c[3:1] & ev);
    endfunction : qual

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn || !bus_reset_n) begin
            {drv_q, pend_q, ie_drv_q, ie_pend_q} <= 4'h0;
        end else begin
            q = qual(cfg, {obs_err, req_err, int_err});
            if (bus_edge) begin
                {drv_q, pend_q} <= {pend_q | q, 1'b0};
                {ie_drv_q, ie_pend_q} <= {ie_pend_q | int_err, 1'b0};
            end else begin
                pend_q <= pend_q | q;
                ie_pend_q <= ie_pend_q | int_err;
            end
        end
    end
    always @(negedge i_clk) begin
        if (chk) begin
            `CHK(mce_oe, drv_q & cfg[0])
            `CHK(ie_oe, ie_drv_q)
        end
    end

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    initial begin
        {i_resetn, rd, wr, addr, wdata, bus_edge, peer_err, chk, cfg} = '0;
        {int_err, req_err, obs_err, err_total, n_compared} = '0;
        bus_reset_n = 1'b1;
        seed = 32'h31BF;
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            access(1'b0, 4'(k * 4), 32'h0);
            `CHK(r, 32'h0)
        end
        access(1'b1, mce_pkg::OFF_LINE + 4'h1, 32'hFFFF_FFFF);
        access(1'b0, mce_pkg::OFF_LINE, 32'h0);
        `CHK(r[15:0], {mce_pkg::AGENT_ID, 8'h00})
        `CHK(ie_n, 1'b0)
        pulse(4'hA);
        `CHK(mce_oe, 1'b0)
        access(1'b0, mce_pkg::OFF_STATUS, 32'h0);
        `CHK(r[3:0], 4'h2)
        for (int m = 1; m < 4; m++) begin
            access(1'b1, mce_pkg::OFF_CTRL, 32'h1 | (32'h1 << m));
            pulse(4'h8 | 4'(1 << (m - 1)));
            `CHK(mce_oe, 1'b1)
            `CHK(ie_oe, 1'(m == 1))
            repeat (3) @(negedge i_clk);
            `CHK(mce_oe, 1'b1)
            pulse(4'h8);
            `CHK(mce_oe, 1'b0)
            pulse(4'(1 << (m - 1)));
            `CHK(mce_oe, 1'b0)
            pulse(4'h8);
            `CHK(mce_oe, 1'b1)
            pulse(4'h8);
        end
        access(1'b1, mce_pkg::OFF_CTRL, 32'h1);
        access(1'b1, mce_pkg::OFF_STATUS, 32'hF);
        @(posedge i_clk);
        peer_err <= 1'b1;
        pulse(4'h8);
        pulse(4'h8);
        `CHK(irq, 1'b0)
        access(1'b1, mce_pkg::OFF_MASK, 32'h8);
        @(negedge i_clk);
        `CHK(irq, 1'b1)
        access(1'b0, mce_pkg::OFF_LINE, 32'h0);
        `CHK(r[2:0], 3'h1)
        @(posedge i_clk);
        peer_err <= 1'b0;
        pulse(4'h8);
        pulse(4'h8);
        access(1'b1, mce_pkg::OFF_STATUS, 32'h8);
        @(negedge i_clk);
        `CHK(irq, 1'b0)
        access(1'b1, mce_pkg::OFF_CTRL, 32'h5);
        pulse(4'hA);
        @(posedge i_clk);
        bus_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        `CHK(mce_oe, 1'b0)
        @(posedge i_clk);
        bus_reset_n <= 1'b1;
        for (int c = 0; c < 6; c++) begin
            access(1'b1, mce_pkg::OFF_CTRL, {28'h0, cfg_tab[c]});
            cfg = cfg_tab[c];
            chk = 1'b1;
            repeat (200) begin
                @(posedge i_clk);
                r = $random(seed);
                {bus_edge, obs_err, req_err, int_err} <=
                    {r[1:0] == 2'h0, r[4:2] == 3'h0, r[7:5] == 3'h0, r[10:8] == 3'h0};
            end
            @(posedge i_clk);
            {bus_edge, obs_err, req_err, int_err} <= 4'h0;
            chk = 1'b0;
        end
        results();
    end
endmodule : bus_machine_check_error_signal_tb
